// ---- hdl/pin_sync.v ----
/*
  two flip-flop synchroniser bank for asynchronous pins.
  assumes inputs are levels from outside the aclk domain.
*/
module pin_sync #(
  parameter N = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pins
  input wire [N-1:0] async_in,
  output reg [N-1:0] sync_out
);

  reg [N-1:0] meta_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {N{1'b0}};
      sync_out <= {N{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ---- hdl/sensor_xcvr_supervisor.v ----
/*
  supervisory logic of a dual-driver sensor line transceiver: wake-up
  detection, open-drain reset / power-good pin, thermal warning and
  shutdown, register damage check and buck soft-start / mode selection.
  assumes analog comparators arrive as asynchronous levels, aclk is the
  internal reference clock at 100 MHz, software uses AXI4-Lite.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`include "supervisor_regs.vh"

module sensor_xcvr_supervisor #(
  parameter TW = 20,
  parameter [TW-1:0] WAKE_CYC = `T_WAKE_US * `CLK_MHZ,
  parameter [TW-1:0] PULSE_CYC = `T_PULSE_US * `CLK_MHZ,
  parameter [TW-1:0] BL0_CYC = `T_BL0_US * `CLK_MHZ,
  parameter [TW-1:0] BL1_CYC = `T_BL1_US * `CLK_MHZ,
  parameter [TW-1:0] BL2_CYC = `T_BL2_US * `CLK_MHZ,
  parameter [TW-1:0] BL3_CYC = `T_BL3_US * `CLK_MHZ,
  parameter [TW-1:0] REL_CYC = `T_REL_US * `CLK_MHZ,
  parameter [TW-1:0] SOFT_CYC = `T_SOFT_US * `CLK_MHZ
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // line side
  input wire cq_line_in,
  input wire cq_tx_level,
  input wire cq_driver_on,
  output wire cq_drive_en,
  output wire do_drive_en,
  // reset / power good pin
  input wire reset_pin_in,
  output wire power_good_out,
  output wire power_good_oe,
  // analog monitors
  input wire field_supply_ok,
  input wire five_volt_rail_ok,
  input wire buck_at_95,
  input wire buck_above_103,
  input wire buck_below_101,
  input wire temp_above_147,
  input wire temp_above_170,
  input wire temp_below_153,
  input wire ext_five_volt,
  input wire reg_damage_event,
  // buck control
  output reg buck_enable,
  output reg [1:0] buck_mode,
  output reg switch_node_en,
  // host signals
  output reg wake_out_n,
  output wire irq_n,
  output wire bus_enable
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [10:0] s_in;
  pin_sync #(.N(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({reg_damage_event, temp_below_153, temp_above_170, temp_above_147,
      buck_below_101, buck_above_103, buck_at_95, five_volt_rail_ok,
      field_supply_ok, reset_pin_in, cq_line_in}),
    .sync_out(s_in)
  );
  wire line_s = s_in[0];
  wire pin_s = s_in[1];
  wire field_s = s_in[2];
  wire five_s = s_in[3];
  wire b95_s = s_in[4];
  wire b103_s = s_in[5];
  wire b101_s = s_in[6];
  wire hot_s = s_in[7];
  wire tsd_hi_s = s_in[8];
  wire tsd_lo_s = s_in[9];
  wire damage_s = s_in[10];

  //////////////////////////////////////////////////////////////////////////
  // reset pin, thermal shutdown, power good
  reg tsd_r;
  reg hold_low_r;
  reg pin_s_d_r;
  wire supplies_ok = field_s && five_s && b95_s;
  wire buck_off;
  wire regs_clear = !pin_s || tsd_r;
  wire rel_busy;
  wire rel_done;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tsd_r <= 1'b0;
    end else if (tsd_hi_s) begin
      tsd_r <= 1'b1;
    end else if (tsd_lo_s) begin
      tsd_r <= 1'b0;
    end
  end

  // release timer only used when the buck is off; otherwise release at once
  wire rel_start = pin_s && !pin_s_d_r && buck_off && supplies_ok;
  tick_timer #(.W(TW)) u_rel (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rel_start),
    .stop(!supplies_ok || tsd_r),
    .load(REL_CYC),
    .busy(rel_busy),
    .done(rel_done)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s_d_r <= 1'b0;
      hold_low_r <= 1'b1;
    end else begin
      pin_s_d_r <= pin_s;
      if (!supplies_ok || tsd_r)
        hold_low_r <= 1'b1;
      else if (!buck_off || rel_done)
        hold_low_r <= 1'b0;
    end
  end

  // open drain: only ever drive zero
  assign power_good_out = 1'b0;
  assign power_good_oe = hold_low_r || rel_busy;
  // bus stays live in reset; in shutdown only with an external 5 V rail
  assign bus_enable = !tsd_r || ext_five_volt;

  //////////////////////////////////////////////////////////////////////////
  // registers and their shadow copies
  reg [`CTL_W-1:0] ctl_r;
  reg [`MODE_W-1:0] mode_r;
  reg [`CL_W-1:0] cl_r;
  reg [`INT_W-1:0] mask_r;
  reg [`INT_W-1:0] int_r;
  reg [`CTL_W+`MODE_W+`CL_W+`INT_W-1:0] shadow_r;
  reg damage_r;
  wire [`CTL_W+`MODE_W+`CL_W+`INT_W-1:0] live = {ctl_r, mode_r, cl_r, mask_r};
  assign buck_off = mode_r[`MODE_OFF];

  // write channel: take address and data in either order
  reg aw_have_r;
  reg w_have_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg w_lane0_r;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_ctl = do_write && w_lane0_r && aw_addr_r == `OFS_CONTROL;
  wire wr_mode = do_write && w_lane0_r && aw_addr_r == `OFS_MODE;
  wire wr_cl = do_write && w_lane0_r && aw_addr_r == `OFS_CURRLIM;
  wire wr_mask = do_write && w_lane0_r && aw_addr_r == `OFS_IRQ_MASK;

  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `OFS_CONTROL) || (a == `OFS_MODE) || (a == `OFS_CURRLIM) ||
        (a == `OFS_IRQ_MASK) || (a == `OFS_INTERRUPT) || (a == `OFS_STATUS);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_lane0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // registers are wiped while the reset pin is low or in shutdown
  always @(posedge aclk) begin
    if (!aresetn || regs_clear) begin
      ctl_r <= `CTL_RST;
      mode_r <= `MODE_RST;
      cl_r <= `CL_RST;
      mask_r <= `MASK_RST;
      shadow_r <= {`CTL_RST, `MODE_RST, `CL_RST, `MASK_RST};
    end else begin
      if (wr_ctl)
        ctl_r <= w_data_r[`CTL_W-1:0];
      if (wr_mode)
        mode_r <= w_data_r[`MODE_W-1:0];
      if (wr_cl)
        cl_r <= w_data_r[`BLANK_TIME_SEL_LSB+`CL_W-1:`BLANK_TIME_SEL_LSB];
      if (wr_mask)
        mask_r <= w_data_r[`INT_W-1:0];
      // an upset flips a live bit but never the shadow copy
      if (damage_s)
        ctl_r[`CTL_CQ_EN] <= ~ctl_r[`CTL_CQ_EN];
      if ((wr_ctl || wr_mode || wr_cl || wr_mask) && !damage_r)
        shadow_r <= {wr_ctl ? w_data_r[`CTL_W-1:0] : ctl_r,
          wr_mode ? w_data_r[`MODE_W-1:0] : mode_r,
          wr_cl ? w_data_r[`CL_W-1:0] : cl_r,
          wr_mask ? w_data_r[`INT_W-1:0] : mask_r};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel; reading the interrupt register clears its flags, unready only while no damage is flagged
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  wire rd_int = rd_take && ra == `OFS_INTERRUPT;
  assign s_axi_arready = !s_axi_rvalid;
  reg soft_r;
  wire [`ST_W-1:0] status = {soft_r, tsd_r, damage_r, hot_s};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_known(ra) ? `RESP_OKAY : `RESP_SLVERR;
      case (ra)
        `OFS_CONTROL: s_axi_rdata <= {{(32-`CTL_W){1'b0}}, ctl_r};
        `OFS_MODE: s_axi_rdata <= {{(32-`MODE_W){1'b0}}, mode_r};
        `OFS_CURRLIM: s_axi_rdata <= {{(32-`CL_W){1'b0}}, cl_r};
        `OFS_IRQ_MASK: s_axi_rdata <= {{(32-`INT_W){1'b0}}, mask_r};
        `OFS_INTERRUPT: s_axi_rdata <= {{(32-`INT_W){1'b0}}, int_r};
        `OFS_STATUS: s_axi_rdata <= {{(32-`ST_W){1'b0}}, status};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake-up detection
  reg tx_d_r;
  wire tx_change = (cq_tx_level != tx_d_r);
  wire bl_busy;
  wire qual_done;
  wire pulse_busy;
  reg [TW-1:0] bl_load;
  always @* begin
    case (cl_r)
      2'h0: bl_load = BL0_CYC;
      2'h1: bl_load = BL1_CYC;
      2'h2: bl_load = BL2_CYC;
      default: bl_load = BL3_CYC;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn)
      tx_d_r <= 1'b0;
    else
      tx_d_r <= cq_tx_level;
  end

  tick_timer #(.W(TW)) u_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tx_change),
    .stop(1'b0),
    .load(bl_load),
    .busy(bl_busy),
    .done()
  );

  // opposing level while the driver is active, outside blanking
  wire opposed = cq_drive_en && cq_driver_on && (line_s != cq_tx_level) && !bl_busy &&
    !ctl_r[`CTL_WAKE_OFF] && !tx_change;
  reg opposed_d_r;
  always @(posedge aclk) begin
    if (!aresetn)
      opposed_d_r <= 1'b0;
    else
      opposed_d_r <= opposed;
  end

  tick_timer #(.W(TW)) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(opposed && !opposed_d_r),
    .stop(!opposed),
    .load(WAKE_CYC),
    .busy(),
    .done(qual_done)
  );

  tick_timer #(.W(TW)) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(qual_done),
    .stop(1'b0),
    .load(PULSE_CYC),
    .busy(pulse_busy),
    .done()
  );

  always @(posedge aclk) begin
    if (!aresetn)
      wake_out_n <= 1'b1;
    else
      wake_out_n <= !(qual_done || pulse_busy);
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt flags and damage status; sets win over clears
  always @(posedge aclk) begin
    if (!aresetn || regs_clear) begin
      int_r <= {`INT_W{1'b0}};
      damage_r <= 1'b0;
    end else begin
      if (damage_s)
        damage_r <= 1'b1;
      else if (damage_r && live == shadow_r)
        damage_r <= 1'b0;
      if (rd_int)
        int_r[`INT_WAKE] <= 1'b0;
      if (qual_done)
        int_r[`INT_WAKE] <= 1'b1;
      if (rd_int)
        int_r[`INT_HOT] <= 1'b0;
      if (hot_s)
        int_r[`INT_HOT] <= 1'b1;
      if (rd_int && !damage_r)
        int_r[`INT_UNREADY] <= 1'b0;
      if (damage_s)
        int_r[`INT_UNREADY] <= 1'b1;
    end
  end

  // unready is never maskable
  assign irq_n = !(|(int_r & ~mask_r & {1'b0, {(`INT_W-1){1'b1}}}) ||
    int_r[`INT_UNREADY]);

  // drivers: off in reset, shutdown or unready
  wire drv_ok = !hold_low_r && pin_s && !tsd_r && !int_r[`INT_UNREADY];
  assign cq_drive_en = drv_ok && ctl_r[`CTL_CQ_EN];
  assign do_drive_en = drv_ok && ctl_r[`CTL_DO_EN];

  //////////////////////////////////////////////////////////////////////////
  // buck soft-start and mode
  wire soft_done;
  reg field_d_r;
  always @(posedge aclk) begin
    if (!aresetn)
      field_d_r <= 1'b0;
    else
      field_d_r <= field_s;
  end

  tick_timer #(.W(TW)) u_soft (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(field_s && !field_d_r),
    .stop(!field_s),
    .load(SOFT_CYC),
    .busy(),
    .done(soft_done)
  );

  function [1:0] mode_dec;
    input [`MODE_W-1:0] m;
    begin
      if (m[`MODE_DCM])
        mode_dec = `BUCK_DCM;
      else if (m[`MODE_PFM])
        mode_dec = `BUCK_PFM;
      else
        mode_dec = `BUCK_PWM;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_r <= 1'b0;
      buck_enable <= 1'b0;
      buck_mode <= `BUCK_STOP;
      switch_node_en <= 1'b0;
    end else begin
      if (!field_s || tsd_r)
        soft_r <= 1'b0;
      else if (field_s && !field_d_r)
        soft_r <= 1'b1;
      else if (b95_s || soft_done)
        soft_r <= 1'b0;
      buck_enable <= field_s && !tsd_r && !buck_off;
      if (!field_s || tsd_r || buck_off)
        buck_mode <= `BUCK_STOP;
      else if (soft_r)
        buck_mode <= `BUCK_DCM;
      else
        buck_mode <= mode_dec(mode_r);
      if (!field_s || tsd_r || buck_off)
        switch_node_en <= 1'b0;
      else if (!soft_r && mode_dec(mode_r) == `BUCK_PFM) begin
        if (b103_s)
          switch_node_en <= 1'b0;
        else if (b101_s)
          switch_node_en <= 1'b1;
      end else
        switch_node_en <= 1'b1;
    end
  end

endmodule

// ---- hdl/tick_timer.v ----
/*
  one-shot down counter started by a pulse; done pulses when it expires.
  assumes start and load come from logic on aclk.
*/
`include "supervisor_regs.vh"

module tick_timer #(
  parameter W = 20
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire start,
  input wire stop,
  input wire [W-1:0] load,
  // status
  output wire busy,
  output reg done
);

  reg [W-1:0] cnt_r;

  assign busy = (cnt_r != {W{1'b0}});

  always @(posedge aclk) begin
    if (!aresetn || stop) begin
      cnt_r <= {W{1'b0}};
      done <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      done <= 1'b0;
    end else begin
      done <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
      if (busy)
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ---- pkg/supervisor_regs.vh ----
/*
  register offsets, field positions, reset values and timing figures of the
  transceiver supervisor. assumes aclk at 100 MHz and an AXI4-Lite host.
*/
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH

// byte offsets
`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_CURRLIM 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_INTERRUPT 8'h10
`define OFS_STATUS 8'h14

// control fields
`define CTL_WAKE_OFF 0
`define CTL_CQ_EN 1
`define CTL_DO_EN 2
`define CTL_W 3
`define CTL_RST 3'h0
// mode fields
`define MODE_PFM 0
`define MODE_DCM 1
`define MODE_OFF 2
`define MODE_W 3
`define MODE_RST 3'h0
// blank time field
`define BLANK_TIME_SEL_LSB 0
`define CL_W 2
`define CL_RST 2'h0
// mask and interrupt bit positions
`define INT_WAKE 0
`define INT_HOT 1
`define INT_UNREADY 2
`define INT_W 3
`define MASK_RST 3'h0
// status bit positions
`define ST_HOT 0
`define ST_DAMAGE 1
`define ST_TSD 2
`define ST_SOFTSTART 3
`define ST_W 4

// buck mode encodings
`define BUCK_PWM 2'h0
`define BUCK_PFM 2'h1
`define BUCK_DCM 2'h2
`define BUCK_STOP 2'h3

// times in microseconds, scaled by the clock rate
`define CLK_MHZ 100
`define T_WAKE_US 80
`define T_PULSE_US 200
`define T_BL0_US 128
`define T_BL1_US 500
`define T_BL2_US 1000
`define T_BL3_US 5000
`define T_REL_US 4000
`define T_SOFT_US 2220

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verif/line_master.sv ----
/*
  line master on the sensor line and pull-up of the reset pin.
  assumes the bench calls wake_req just after a rising clock edge.
*/
module line_master (
  // clock
  input wire aclk,
  // sensor line
  input wire cq_tx_level,
  input wire cq_driver_on,
  output wire cq_line_in,
  // reset pin
  input wire power_good_oe,
  input wire host_pull,
  output wire reset_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oppose = 1'b0;
  logic flip = 1'b0;
  always @(posedge aclk) flip <= ~flip;
  task automatic wake_req(input int n);
    oppose <= 1'b1;
    repeat (n) @(posedge aclk);
    oppose <= 1'b0;
  endtask
  // an undriven line floats, shown as a toggling level
  assign cq_line_in = !cq_driver_on ? flip : (oppose ? !cq_tx_level : cq_tx_level);
  assign reset_pin_in = !(power_good_oe || host_pull);
endmodule

// ---- verif/sensor_xcvr_supervisor_tb.sv ----
/*
  self-checking bench of the transceiver supervisor over AXI4-Lite.
  assumes shortened counts: wake 20, pulse 40, blank 10..40 cycles.
*/
`include "supervisor_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module sensor_xcvr_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, cq_tx_level = 1, cq_driver_on = 1, host_pull = 0, ext_five_volt = 1;
  logic field_supply_ok = 1, five_volt_rail_ok = 1, buck_at_95 = 0, buck_above_103 = 0;
  logic buck_below_101 = 1, temp_above_147 = 0, temp_above_170 = 0, temp_below_153 = 1;
  logic reg_damage_event = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cq_line_in;
  wire [1:0] s_axi_bresp, s_axi_rresp, buck_mode;
  wire [31:0] s_axi_rdata;
  wire cq_drive_en, do_drive_en, reset_pin_in, power_good_out, power_good_oe, buck_enable;
  wire switch_node_en, wake_out_n, irq_n, bus_enable;
  int n_errors = 0, samples_checked = 0;
  logic [1:0] mexp [5] = '{`BUCK_PWM, `BUCK_PFM, `BUCK_DCM, `BUCK_DCM, `BUCK_STOP};

  sensor_xcvr_supervisor #(.WAKE_CYC(20), .PULSE_CYC(40), .BL0_CYC(10), .BL1_CYC(20),
    .BL2_CYC(30), .BL3_CYC(40), .REL_CYC(50), .SOFT_CYC(60)) i_sensor_xcvr_supervisor (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cq_line_in, .cq_tx_level, .cq_driver_on, .cq_drive_en, .do_drive_en,
    .reset_pin_in, .power_good_out, .power_good_oe, .field_supply_ok, .five_volt_rail_ok,
    .buck_at_95, .buck_above_103, .buck_below_101, .temp_above_147, .temp_above_170,
    .temp_below_153, .ext_five_volt, .reg_damage_event, .buck_enable, .buck_mode,
    .switch_node_en, .wake_out_n, .irq_n, .bus_enable);
  line_master i_line_master (.aclk, .cq_tx_level, .cq_driver_on, .cq_line_in,
    .power_good_oe, .host_pull, .reset_pin_in);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ready and answers are looked at mid-cycle, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ta, tw, b;
    logic [1:0] r;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready && !ta;
      w = s_axi_wready && !tw;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      ta = ta | aw;
      tw = tw | w;
    end while (!(ta && tw));
    do begin
      @(negedge aclk);
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!b);
    s_axi_bready <= 1'b0;
    `CHK(r, `RESP_OKAY)
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
    `CHK(d & m, e)
    `CHK(r, er)
  endtask

  task automatic wake_try(input int n, input logic e);
    i_line_master.wake_req(n);
    repeat (3) @(posedge aclk);
    `CHK(wake_out_n, e)
    repeat (60) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(buck_mode, `BUCK_DCM)
    rc(`OFS_STATUS, 32'h8, 32'h8, `RESP_OKAY);
    rc(8'h20, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    buck_at_95 <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(power_good_oe, 1'b0)
    `CHK(buck_mode, `BUCK_PWM)
    for (int i = 0; i < 4; i++) rc(8'h00 + 8'(4 * i), 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h6);
    `CHK(cq_drive_en, 1'b1)
    $display("reset and soft-start done");

    repeat (50) @(posedge aclk);
    wake_try(25, 1'b0);
    `CHK(irq_n, 1'b0)
    rc(`OFS_INTERRUPT, 32'h1, 32'h1, `RESP_OKAY);
    `CHK(irq_n, 1'b1)
    wake_try(15, 1'b1);
    wr(`OFS_CURRLIM, 32'h3);
    wr(`OFS_IRQ_MASK, 32'h1);
    cq_tx_level <= 1'b0;
    wake_try(25, 1'b1);
    wake_try(25, 1'b0);
    `CHK(irq_n, 1'b1)
    rc(`OFS_INTERRUPT, 32'h1, 32'h1, `RESP_OKAY);
    // a driver that is not active cannot be opposed, so no wake
    cq_driver_on <= 1'b0;
    wake_try(25, 1'b1);
    cq_driver_on <= 1'b1;
    wr(`OFS_CONTROL, 32'h7);
    wake_try(25, 1'b1);
    wr(`OFS_CONTROL, 32'h6);
    $display("wake done");

    temp_above_147 <= 1'b1;
    repeat (6) @(posedge aclk);
    rc(`OFS_STATUS, 32'h1, 32'h1, `RESP_OKAY);
    `CHK(irq_n, 1'b0)
    `CHK(cq_drive_en, 1'b1)
    temp_above_147 <= 1'b0;
    repeat (4) @(posedge aclk);
    rc(`OFS_INTERRUPT, 32'h2, 32'h2, `RESP_OKAY);
    `CHK(irq_n, 1'b1)
    reg_damage_event <= 1'b1;
    @(posedge aclk);
    reg_damage_event <= 1'b0;
    repeat (6) @(posedge aclk);
    rc(`OFS_STATUS, 32'h2, 32'h2, `RESP_OKAY);
    `CHK({irq_n, cq_drive_en, do_drive_en}, 3'h0)
    wr(`OFS_CONTROL, 32'h6);
    rc(`OFS_STATUS, 32'h2, 32'h0, `RESP_OKAY);
    `CHK(irq_n, 1'b0)
    rc(`OFS_INTERRUPT, 32'h4, 32'h4, `RESP_OKAY);
    rc(`OFS_INTERRUPT, 32'h4, 32'h0, `RESP_OKAY);
    `CHK({irq_n, cq_drive_en}, 2'h3)
    $display("thermal warning and damage done");

    for (int i = 0; i < 5; i++) begin
      wr(`OFS_MODE, 32'(i));
      repeat (3) @(posedge aclk);
      `CHK(buck_mode, mexp[i])
      `CHK(buck_enable, i < 4)
    end
    wr(`OFS_MODE, 32'h1);
    buck_above_103 <= 1'b1;
    buck_below_101 <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHK(switch_node_en, 1'b0)
    buck_above_103 <= 1'b0;
    buck_below_101 <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(switch_node_en, 1'b1)
    // low byte lane off: the write is answered but must not land
    s_axi_wstrb <= 4'h0;
    wr(`OFS_MODE, 32'h2);
    s_axi_wstrb <= 4'hF;
    rc(`OFS_MODE, 32'h7, 32'h1, `RESP_OKAY);
    `CHK(buck_mode, `BUCK_PFM)
    $display("buck modes done");

    host_pull <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(cq_drive_en, 1'b0)
    wr(`OFS_CONTROL, 32'h6);
    rc(`OFS_MODE, 32'h7, 32'h0, `RESP_OKAY);
    host_pull <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(power_good_oe, 1'b0)
    field_supply_ok <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(power_good_oe, 1'b1)
    field_supply_ok <= 1'b1;
    five_volt_rail_ok <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(power_good_oe, 1'b1)
    five_volt_rail_ok <= 1'b1;
    // wait for the pin to come back so the write lands before shutdown
    repeat (8) @(posedge aclk);
    wr(`OFS_CONTROL, 32'h6);
    `CHK(cq_drive_en, 1'b1)
    temp_above_170 <= 1'b1;
    temp_below_153 <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK({power_good_oe, buck_enable, bus_enable}, 3'h5)
    ext_five_volt <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(bus_enable, 1'b0)
    ext_five_volt <= 1'b1;
    temp_above_170 <= 1'b0;
    temp_below_153 <= 1'b1;
    repeat (20) @(posedge aclk);
    `CHK(power_good_oe, 1'b0)
    rc(`OFS_CONTROL, 32'h7, 32'h0, `RESP_OKAY);
    $display("reset pin and shutdown done");
    stop_test();
  end
endmodule

// ---- verif/supervisor_chk.sv ----
/*
  port-level assertions for the transceiver supervisor, bound into it.
  assumes aclk is the only clock and aresetn is synchronous, active low.
*/
`include "supervisor_regs.vh"

module supervisor_chk #(
  parameter int PULSE_CYC = 40
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus answers
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // line and pins
  input wire cq_tx_level,
  input wire cq_drive_en,
  input wire do_drive_en,
  input wire power_good_out,
  input wire power_good_oe,
  input wire field_supply_ok,
  input wire five_volt_rail_ok,
  input wire buck_above_103,
  input wire temp_above_170,
  input wire buck_enable,
  input wire [1:0] buck_mode,
  input wire switch_node_en,
  input wire wake_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  // low-time counter of the wake pulse; a repetition would be too long
  logic [15:0] low_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || wake_out_n) low_cnt_r <= 16'h0000;
    else low_cnt_r <= low_cnt_r + 16'h0001;
  end

  sequence uv_s; (!field_supply_ok || !five_volt_rail_ok) [*3]; endsequence
  sequence hot_s; temp_above_170 [*3]; endsequence
  sequence pin_low_s; power_good_oe [*4]; endsequence

  ////////////////////////////////////////////////////////////////////////
  wake_short_a: assert property ($rose(wake_out_n) |-> $past(low_cnt_r) >= PULSE_CYC - 2)
    else $error("wake pulse too short");
  wake_long_a: assert property (low_cnt_r <= PULSE_CYC + 2)
    else $error("wake pulse too long");
  blank_quiet_a: assert property ($changed(cq_tx_level) ##3 wake_out_n |-> wake_out_n [*6])
    else $error("wake seen inside blanking");
  pin_drive_a: assert property (!power_good_out)
    else $error("reset pin driven high");
  reset_drivers_a: assert property (pin_low_s |-> !cq_drive_en && !do_drive_en)
    else $error("driver on while reset low");
  uv_pull_a: assert property (uv_s |-> ##[0:4] power_good_oe)
    else $error("undervoltage did not pull reset");
  shutdown_off_a: assert property (hot_s |-> ##[0:4] (power_good_oe && !buck_enable))
    else $error("shutdown left buck or pin");
  pfm_stop_a: assert property ((buck_mode == `BUCK_PFM && buck_above_103) [*4] |-> !switch_node_en)
    else $error("pfm switching above limit");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind sensor_xcvr_supervisor supervisor_chk #(.PULSE_CYC(PULSE_CYC)) i_supervisor_chk (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cq_tx_level, .cq_drive_en, .do_drive_en, .power_good_out, .power_good_oe,
  .field_supply_ok, .five_volt_rail_ok, .buck_above_103, .temp_above_170, .buck_enable,
  .buck_mode, .switch_node_en, .wake_out_n);
